// File: design/compare_skip_branch_exec.sv
// execution of compares, conditional skips and status-bit branches
// assumes operands are already fetched and stable while opValid is high
module compare_skip_branch_exec (
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           reset_n,
    // decoded operation
    input  wire logic           opValid,
    input  wire cse_pkg::op_e   opCode,
    input  wire logic [7:0]     operandA,
    input  wire logic [7:0]     operandB,
    input  wire logic [7:0]     ioValue,
    input  wire logic [2:0]     bitSel,
    input  wire logic [6:0]     branchOffset,
    input  wire logic           nextIsLong,
    // status register write-back from elsewhere
    input  wire logic           statusLoad,
    input  wire logic [7:0]     statusIn,
    // results
    output logic [15:0]         pc_q,
    output logic [7:0]          status_q,
    output logic                skipTaken_q,
    output logic                branchTaken_q
);
    import cse_pkg::*;

    // ****************************************************************
    // subtraction for compares
    // ****************************************************************
    logic       carryIn;
    logic [7:0] rhs;
    logic [7:0] diff;
    logic       cOut;
    logic       hOut;
    logic       vOut;
    logic       isCompare;
    logic       isCarryCmp;
    logic       sameRegs;

    assign isCompare  = opValid && (opCode == OP_COMPARE_REGS ||
                        opCode == OP_COMPARE_REGS_CARRY ||
                        opCode == OP_COMPARE_IMMEDIATE);
    assign isCarryCmp = opCode == OP_COMPARE_REGS_CARRY;
    assign sameRegs   = operandA == operandB;
    assign carryIn    = isCarryCmp & status_q[FLAG_C];
    assign rhs        = operandB; // immediate arrives on operandB too
    assign diff       = operandA - rhs - {7'h00, carryIn};
    assign cOut = (~operandA[7] & rhs[7]) | (rhs[7] & diff[7])
                | (diff[7] & ~operandA[7]);
    assign hOut = (~operandA[3] & rhs[3]) | (rhs[3] & diff[3])
                | (diff[3] & ~operandA[3]);
    assign vOut = (operandA[7] & ~rhs[7] & ~diff[7])
                | (~operandA[7] & rhs[7] & diff[7]);

    // ****************************************************************
    // skip and branch conditions
    // ****************************************************************
    logic skipCond;
    logic branchCond;
    always_comb begin
        skipCond   = 1'b0;
        branchCond = 1'b0;
        if (opValid) begin
            unique case (opCode)
                OP_COMPARE_SKIP_EQUAL: skipCond = sameRegs; // [RQ1]
                OP_SKIP_REG_BIT_CLEAR: skipCond = !operandA[bitSel]; // [RQ3]
                OP_SKIP_REG_BIT_SET:   skipCond = operandA[bitSel]; // [RQ4]
                OP_SKIP_IO_BIT_CLEAR:  skipCond = !ioValue[bitSel]; // [RQ8]
                OP_SKIP_IO_BIT_SET:    skipCond = ioValue[bitSel]; // [RQ5]
                OP_BRANCH_FLAG_SET:    branchCond = status_q[bitSel]; // [RQ6]
                OP_BRANCH_FLAG_CLEAR:  branchCond = !status_q[bitSel]; // [RQ7]
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // program counter
    // ****************************************************************
    logic [15:0] pc_d;
    always_comb begin
        pc_d = pc_q;
        if (opValid) begin
            if (skipCond)
                pc_d = pc_q + (nextIsLong ? SKIP_LONG : SKIP_SHORT); // [RQ1]
            else if (branchCond)
                // offset sign-extended; plus one past the branch [RQ6] [RQ7]
                pc_d = pc_q + {{9{branchOffset[6]}}, branchOffset} + PC_STEP;
            else
                pc_d = pc_q + PC_STEP;
        end
    end

    // pc and event flags advance once per accepted operation
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pc_q          <= PC_RESET;
            skipTaken_q   <= 1'b0;
            branchTaken_q <= 1'b0;
        end else begin
            pc_q          <= pc_d;
            skipTaken_q   <= skipCond;
            branchTaken_q <= branchCond;
        end
    end

    // ****************************************************************
    // status register
    // ****************************************************************
    // carry compare keeps zero sticky so multi-byte compares chain
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RESET;
        end else if (isCompare) begin
            status_q[FLAG_C] <= cOut; // [RQ2]
            status_q[FLAG_H] <= hOut;
            status_q[FLAG_V] <= vOut;
            status_q[FLAG_N] <= diff[7];
            status_q[FLAG_S] <= diff[7] ^ vOut;
            status_q[FLAG_Z] <= isCarryCmp ? (diff == 8'h00) & status_q[FLAG_Z]
                                           : (diff == 8'h00);
        end else if (statusLoad) begin
            status_q <= statusIn;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // operand values are those of the cycle in which the op was taken
    a_equal_skip_pc: assert property ( // [RQ1]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_SKIP_EQUAL && operandA == operandB
        |=> pc_q == $past(pc_q)
            + ($past(nextIsLong) ? SKIP_LONG : SKIP_SHORT))
        else $error("equal skip pc wrong");
    a_compare_zero: assert property ( // [RQ2]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_REGS
        |=> status_q[FLAG_Z] == ($past(operandA) == $past(operandB)))
        else $error("compare zero flag wrong");
    a_compare_carry: assert property ( // [RQ2]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_IMMEDIATE
        |=> status_q[FLAG_C] == ($past(operandA) < $past(operandB)))
        else $error("compare carry wrong");
    a_regbit_clear: assert property ( // [RQ3]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_REG_BIT_CLEAR && !operandA[bitSel]
        && !statusLoad |=> skipTaken_q && $stable(status_q))
        else $error("reg bit clear skip wrong");
    a_regbit_set: assert property ( // [RQ4]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_REG_BIT_SET && !operandA[bitSel]
        |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("reg bit set no-skip wrong");
    a_iobit_set: assert property ( // [RQ5]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_IO_BIT_SET
        |=> skipTaken_q == $past(ioValue[bitSel]))
        else $error("io bit set skip wrong");
    a_iobit_clear: assert property ( // [RQ8]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_IO_BIT_CLEAR
        |=> skipTaken_q != $past(ioValue[bitSel]))
        else $error("io bit clear skip wrong");
    a_branch_set: assert property ( // [RQ6]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_BRANCH_FLAG_SET && status_q[bitSel]
        |=> branchTaken_q && pc_q == $past(pc_q)
            + {{9{$past(branchOffset[6])}}, $past(branchOffset)} + PC_STEP)
        else $error("branch set target wrong");
    a_branch_clear: assert property ( // [RQ7]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_BRANCH_FLAG_CLEAR && status_q[bitSel]
        |=> !branchTaken_q && pc_q == $past(pc_q) + PC_STEP)
        else $error("branch clear fall-through wrong");

    // ****************************************************************
    // fall-through paths, untouched flags, compare flags and taken branches
    // ****************************************************************
    // a skip on a mismatch would silently drop the next instruction
    a_equal_no_skip: assert property ( // [RQ1]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_SKIP_EQUAL && operandA != operandB
        |=> !skipTaken_q && pc_q == $past(pc_q) + PC_STEP)
        else $error("equal skip taken on mismatch");
    a_equal_flags: assert property ( // [RQ1]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_SKIP_EQUAL && !statusLoad
        |=> $stable(status_q))
        else $error("equal skip touched status");
    // zero may only stay set while every byte of a chain matched
    a_chain_zero: assert property ( // [RQ2]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_REGS_CARRY
        |=> status_q[FLAG_Z] == ($past(status_q[FLAG_Z])
            && $past(operandA)
               == $past(operandB) + {7'h00, $past(status_q[FLAG_C])}))
        else $error("carry compare zero chain wrong");
    // negative xor overflow is the signed less-than of the operands
    a_compare_sign: assert property ( // [RQ2]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_COMPARE_REGS
        |=> (status_q[FLAG_N] ^ status_q[FLAG_V])
            == ($signed($past(operandA)) < $signed($past(operandB))))
        else $error("compare sign flags wrong");
    a_compare_step: assert property ( // [RQ2]
        @(posedge mclk) disable iff (!reset_n)
        opValid && (opCode == OP_COMPARE_REGS
        || opCode == OP_COMPARE_REGS_CARRY
        || opCode == OP_COMPARE_IMMEDIATE)
        |=> !skipTaken_q && !branchTaken_q && pc_q == $past(pc_q) + PC_STEP)
        else $error("compare moved pc wrongly");
    a_regbit_keep: assert property ( // [RQ3]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_REG_BIT_CLEAR && operandA[bitSel]
        |=> !skipTaken_q && pc_q == $past(pc_q) + PC_STEP)
        else $error("reg bit clear skipped on a one");
    a_regbit_flags: assert property ( // [RQ4]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_REG_BIT_SET && operandA[bitSel]
        && !statusLoad |=> skipTaken_q && $stable(status_q))
        else $error("reg bit set skip wrong");
    a_io_set_flags: assert property ( // [RQ5]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_IO_BIT_SET && !statusLoad
        |=> $stable(status_q))
        else $error("io bit set skip touched status");
    a_io_clr_flags: assert property ( // [RQ8]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_SKIP_IO_BIT_CLEAR && !statusLoad
        |=> $stable(status_q))
        else $error("io bit clear skip touched status");
    a_branch_fall: assert property ( // [RQ6]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_BRANCH_FLAG_SET && !status_q[bitSel]
        |=> !branchTaken_q && pc_q == $past(pc_q) + PC_STEP)
        else $error("branch set taken on a clear bit");
    a_branch_taken: assert property ( // [RQ7]
        @(posedge mclk) disable iff (!reset_n)
        opValid && opCode == OP_BRANCH_FLAG_CLEAR && !status_q[bitSel]
        |=> branchTaken_q && pc_q == $past(pc_q)
            + {{9{$past(branchOffset[6])}}, $past(branchOffset)} + PC_STEP)
        else $error("branch clear target wrong");
endmodule

// File: design/cse_pkg.sv
// constants and encodings for the compare / skip / branch execution unit
// assumes a decoder upstream that presents one decoded operation per cycle
// Summary of operation
// RQ1 - on equal registers the pc skips 2 or 3 words, flags kept.
// RQ2 - compares subtract unstored and set Z, N, V, C and H from it.
// RQ3 - a cleared register bit skips the next instruction, flags kept.
// RQ4 - a set register bit skips the next instruction, flags kept.
// RQ5 - a set I/O bit skips the next instruction, flags kept.
// RQ6 - a set status bit loads pc plus offset plus one, else pc steps.
// RQ7 - a clear status bit loads pc plus offset plus one, else pc steps.
// RQ8 - a cleared I/O bit skips the next instruction, flags kept.
package cse_pkg;
    // ****************************************************************
    // operation codes
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_NONE               = 4'h0,
        OP_COMPARE_SKIP_EQUAL = 4'h1,
        OP_COMPARE_REGS       = 4'h2,
        OP_COMPARE_REGS_CARRY = 4'h3,
        OP_COMPARE_IMMEDIATE  = 4'h4,
        OP_SKIP_REG_BIT_CLEAR = 4'h5,
        OP_SKIP_REG_BIT_SET   = 4'h6,
        OP_SKIP_IO_BIT_CLEAR  = 4'h7,
        OP_SKIP_IO_BIT_SET    = 4'h8,
        OP_BRANCH_FLAG_SET    = 4'h9,
        OP_BRANCH_FLAG_CLEAR  = 4'ha
    } op_e;

    // ****************************************************************
    // status register field positions
    // ****************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [15:0] PC_STEP      = 16'h0001;
    localparam logic [15:0] SKIP_SHORT   = 16'h0002; // next is one word
    localparam logic [15:0] SKIP_LONG    = 16'h0003; // next is two words
endpackage

// File: dv/tb_compare_skip_branch_exec.sv
// self-checking bench for the compare / skip / branch execution unit
// assumes one op taken per rising mclk, results visible after that edge
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin numErrors++; \
$display("BAD %0t got %h want %h", $time, g, e); end end
module tb_compare_skip_branch_exec import cse_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic        mclk = 1'b0, reset_n = 1'b0, opValid = 1'b0;
    logic        nextIsLong = 1'b0, statusLoad = 1'b0;
    op_e         opCode = OP_NONE;
    logic [7:0]  operandA = 8'h00, operandB = 8'h00, statusIn = 8'h00;
    logic [7:0]  ioValue = 8'h00;
    logic [2:0]  bitSel = 3'h0;
    logic [6:0]  branchOffset = 7'h00;
    logic [15:0] pc_q, expPc = PC_RESET;
    logic [7:0]  status_q;
    logic        skipTaken_q, branchTaken_q;
    int          numErrors = 0, checkCount = 0;

    // io value driven apart from operandB so a wrong source shows up
    compare_skip_branch_exec i_dut (.mclk(mclk), .reset_n(reset_n),
        .opValid(opValid), .opCode(opCode), .operandA(operandA),
        .operandB(operandB), .ioValue(ioValue), .bitSel(bitSel),
        .branchOffset(branchOffset), .nextIsLong(nextIsLong),
        .statusLoad(statusLoad), .statusIn(statusIn), .pc_q(pc_q),
        .status_q(status_q), .skipTaken_q(skipTaken_q),
        .branchTaken_q(branchTaken_q));

    // 200 MHz core clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // ****************************************************************
    // shared drivers
    // ****************************************************************
    // opValid stays high so consecutive calls run back to back
    task automatic step(input op_e op, input logic [7:0] a, b, io,
        input logic [2:0] s, input logic [6:0] k, input logic lng,
        input logic [15:0] adv, input logic [1:0] fl, input logic [7:0] st);
        @(negedge mclk);
        opValid = 1'b1;
        opCode = op;
        operandA = a;
        operandB = b;
        ioValue = io;
        bitSel = s;
        branchOffset = k;
        nextIsLong = lng;
        @(posedge mclk);
        #1;
        expPc = expPc + adv;
        `CHK(pc_q, expPc)
        `CHK({skipTaken_q, branchTaken_q}, fl)
        `CHK(status_q, st)
    endtask

    task automatic load_status(input logic [7:0] v);
        @(negedge mclk);
        opValid = 1'b0;
        statusLoad = 1'b1;
        statusIn = v;
        @(negedge mclk);
        statusLoad = 1'b0;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic sc_equal_skip();
        step(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 8'h00, 3'h0, 7'h00, 1'b0,
             16'h2, 2'b10, 8'h00);
        step(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b, 8'h00, 3'h0, 7'h00, 1'b1,
             16'h1, 2'b00, 8'h00);
        step(OP_COMPARE_SKIP_EQUAL, 8'hff, 8'hff, 8'h00, 3'h0, 7'h00, 1'b1,
             16'h3, 2'b10, 8'h00);
    endtask

    // carry compare chains Z; top two status bits must survive
    task automatic sc_compares();
        load_status(8'hc3);
        step(OP_COMPARE_REGS_CARRY, 8'h05, 8'h04, 8'h00, 3'h0, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hc2);
        step(OP_COMPARE_REGS, 8'h00, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hf5);
        step(OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hf8);
        step(OP_COMPARE_REGS_CARRY, 8'h10, 8'h10, 8'h00, 3'h0, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hc0);
    endtask

    // the io value carries the opposite bit so a wrong source shows up
    task automatic sc_reg_skips();
        step(OP_SKIP_REG_BIT_CLEAR, 8'hf7, 8'h00, 8'h08, 3'h3, 7'h00, 1'b0,
             16'h2, 2'b10, 8'hc0);
        step(OP_SKIP_REG_BIT_CLEAR, 8'h08, 8'h00, 8'h00, 3'h3, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hc0);
        step(OP_SKIP_REG_BIT_SET, 8'hf7, 8'h00, 8'h08, 3'h3, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hc0);
        step(OP_SKIP_REG_BIT_SET, 8'h80, 8'h00, 8'h00, 3'h7, 7'h00, 1'b1,
             16'h3, 2'b10, 8'hc0);
    endtask

    // operandB holds the inverse of the io value in every io skip
    task automatic sc_io_skips();
        step(OP_SKIP_IO_BIT_SET, 8'h00, 8'hfe, 8'h01, 3'h0, 7'h00, 1'b0,
             16'h2, 2'b10, 8'hc0);
        step(OP_SKIP_IO_BIT_SET, 8'h00, 8'h01, 8'hfe, 3'h0, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hc0);
        step(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'hfe, 8'h01, 3'h0, 7'h00, 1'b0,
             16'h1, 2'b00, 8'hc0);
        step(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h01, 8'hfe, 3'h0, 7'h00, 1'b1,
             16'h3, 2'b10, 8'hc0);
    endtask

    // a negative offset checks sign extension of the 7-bit field
    task automatic sc_branches();
        load_status(8'h02);
        step(OP_BRANCH_FLAG_SET, 8'h00, 8'h00, 8'h00, 3'h1, 7'h05, 1'b0,
             16'h6, 2'b01, 8'h02);
        step(OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 8'h00, 3'h1, 7'h05, 1'b0,
             16'h1, 2'b00, 8'h02);
        step(OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7e, 1'b0,
             16'hffff, 2'b01, 8'h02);
        step(OP_BRANCH_FLAG_SET, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7e, 1'b0,
             16'h1, 2'b00, 8'h02);
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", numErrors, checkCount);
        if (numErrors == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence: two cycles of reset, then every scenario
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        sc_equal_skip();
        sc_compares();
        sc_reg_skips();
        sc_io_skips();
        sc_branches();
        report_and_stop();
    end

    // watchdog: the tests need about 26 cycles, allow far more
    initial begin
        #10000;
        numErrors++;
        report_and_stop();
    end
endmodule
